// File: core/mhf_core.v
// Modem pin, handshake and flow control logic for one channel
//
// Notes on behaviour
// - Register shows modem pins active high
// - Shared pin: DTR out when select high
// - Per-pin enabled edges set change bits
// - Change bit plus enable raises modem interrupt while SCAN_SELECT high
// - Inputs sampled faster than every 250 us
// - Auto RTS: enabled and data waiting
// - Auto CTS: no character starts without CTS
// - Auto DSR gates the receiver
// - Nonzero command executed, then cleared
// - Remote stop/restart drives transmit flow bits
// - Enable, disable, reset clear transmit flow bits
// - Send Xon/Xoff commands drive receive flow bits
// - In-band Xoff stops after queued characters
// - Resume on Xon, or any char if implied
// - Transmit enable overrides pending Xoff stop
// - CTS drop stops after queued characters
// - DTR threshold: low four bits, zero disables
// - DTR drops at threshold, returns after service
// - Receive enable/disable/reset command steers DTR
// - Disable or reset drops auto RTS after character
// - Device reset deactivates all modem outputs
// - Threshold code selects one to fifteen characters
`include "mhf_defines.vh"

module mhf_core #(
    parameter ADDR_W        = 8,
    parameter SAMPLE_CYCLES = `MHF_SMP_CYC
) (
    // Clock, reset, enable
    input  wire              SYS_CLK,
    input  wire              ARST_N,
    input  wire              CLK_EN,
    // AXI4-Lite write channels
    input  wire [ADDR_W-1:0] AWADDR,
    input  wire              AWVALID,
    output reg               AWREADY,
    input  wire [31:0]       WDATA,
    input  wire [3:0]        WSTRB,
    input  wire              WVALID,
    output reg               WREADY,
    output reg  [1:0]        BRESP,
    output reg               BVALID,
    input  wire              BREADY,
    // AXI4-Lite read channels
    input  wire [ADDR_W-1:0] ARADDR,
    input  wire              ARVALID,
    output reg               ARREADY,
    output reg  [31:0]       RDATA,
    output reg  [1:0]        RRESP,
    output reg               RVALID,
    input  wire              RREADY,
    // Modem pins, active low except DTR_CD_N_OE and DTR_DIR_SEL
    output reg               RTS_N,
    input  wire              CTS_N,
    input  wire              DSR_N,
    input  wire              DTR_CD_N_I,
    output reg               DTR_CD_N_O,
    output reg               DTR_CD_N_OE,
    input  wire              DTR_DIR_SEL,
    // Transmitter side, same clock
    input  wire              TX_DATA_WAITING,
    input  wire              TX_SHIFT_BUSY,
    input  wire              TX_CHAR_START,
    output reg               TX_ALLOW,
    output reg               SEND_XON,
    output reg               SEND_XOFF,
    // Receiver side, same clock
    input  wire              RX_CHAR_STROBE,
    input  wire              RX_CHAR_IS_XON,
    input  wire              RX_CHAR_IS_XOFF,
    input  wire [3:0]        RX_FIFO_LEVEL,
    input  wire              RX_SERVICED,
    output reg               RX_ENABLE,
    // Interrupt scanner
    input  wire              SCAN_SELECT,
    output reg               MODEM_IRQ_N
);

    localparam integer SMP_TOP_I = SAMPLE_CYCLES - 1;
    localparam [13:0]  SMP_TOP   = SMP_TOP_I[13:0];

    // Bus state
    reg [ADDR_W-1:0] waddr_q;
    reg [7:0]        wdata_q;
    reg              wlane_q;
    // Software registers
    reg [1:0]        sig_q;
    reg [7:0]        mco1_q;
    reg [7:0]        mco2_q;
    reg [2:0]        chg_q;
    reg [7:0]        ien_q;
    reg [4:0]        opt2_q;
    reg [3:0]        opt3_q;
    reg [6:0]        cmd_q;
    // Channel state
    reg              tx_en_q;
    reg              rx_en_q;
    reg              txfoff_q;
    reg              txfon_q;
    reg              rxfoff_q;
    reg              rxfon_q;
    reg              dtr_off_q;
    reg              rts_hold_q;
    reg [2:0]        prev_q;
    reg [13:0]       smp_cnt_q;
    // Combinational
    reg [7:0]        rd_d;
    reg              rd_ok_d;
    reg              wr_ok_d;
    wire [3:0]       syn;
    wire [2:0]       cur;
    wire [2:0]       evt;
    wire [6:0]       ex;
    wire             do_wr;
    wire             smp_tick;
    wire             cts_a;
    wire             dsr_a;
    wire             dir_out;
    wire             dtr_fc;
    wire [3:0]       dtr_th;
    wire [3:0]       rx_th;
    wire             rx_flow_chr;
    wire             rts_act;
    wire             dtr_act;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    mhf_sync #(
        .W   (4),
        .RST (`MHF_RST_PINS)
    ) u_sync (
        .clk    (SYS_CLK),
        .arst_n (ARST_N),
        .ce     (CLK_EN),
        .d      ({DTR_DIR_SEL, DSR_N, DTR_CD_N_I, CTS_N}),
        .q      (syn)
    );

    // Pin levels turned active high
    // invert active-low pins
    assign cts_a   = ~syn[0];
    assign dsr_a   = ~syn[2];
    assign dir_out = syn[3];
    assign cur     = {dsr_a, ~syn[1] & ~dir_out, cts_a};

    // ------------------------------------------------------------
    // Modem input sampling and change detection
    // ------------------------------------------------------------
    // sample tick below 250 us
    assign smp_tick = (smp_cnt_q == SMP_TOP);

    assign evt = smp_tick ?
        ((cur & ~prev_q & mco1_q[`MHF_CHG_HI:`MHF_CHG_LO]) |
         (~cur & prev_q & mco2_q[`MHF_CHG_HI:`MHF_CHG_LO])) :
        3'h0;

    // Interval counter and previous sample
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            smp_cnt_q <= 14'h0000;
            prev_q    <= 3'h0;
        end else if (CLK_EN) begin
            if (smp_tick) begin
                smp_cnt_q <= 14'h0000;
                prev_q    <= cur;
            end else begin
                smp_cnt_q <= smp_cnt_q + 14'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    // Address and data in either order; write once both held.
    assign do_wr = ~AWREADY & ~WREADY & ~BVALID;

    // Write address, data and response
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            AWREADY <= 1'b1;
            WREADY  <= 1'b1;
            BVALID  <= 1'b0;
            BRESP   <= `MHF_RESP_OK;
            waddr_q <= {ADDR_W{1'b0}};
            wdata_q <= 8'h00;
            wlane_q <= 1'b0;
        end else if (CLK_EN) begin
            if (AWVALID && AWREADY) begin
                AWREADY <= 1'b0;
                waddr_q <= AWADDR;
            end
            if (WVALID && WREADY) begin
                WREADY  <= 1'b0;
                wdata_q <= WDATA[7:0];
                wlane_q <= WSTRB[0];
            end
            if (do_wr) begin
                BVALID <= 1'b1;
                BRESP  <= wr_ok_d ? `MHF_RESP_OK : `MHF_RESP_ERR;
            end else if (BVALID && BREADY) begin
                BVALID  <= 1'b0;
                AWREADY <= 1'b1;
                WREADY  <= 1'b1;
            end
        end
    end

    // Writable offsets; status word is read only
    always @* begin
        case (waddr_q)
            `MHF_OFF_SIG, `MHF_OFF_MCO1, `MHF_OFF_MCO2,
            `MHF_OFF_CHG, `MHF_OFF_IEN, `MHF_OFF_OPT2,
            `MHF_OFF_OPT3, `MHF_OFF_CMD: wr_ok_d = 1'b1;
            default:                      wr_ok_d = 1'b0;
        endcase
    end

    // Read data mux
    // pin states read active high
    always @* begin
        rd_d    = 8'h00;
        rd_ok_d = 1'b1;
        case (ARADDR)
            `MHF_OFF_SIG:  rd_d = {dir_out, cur, 2'h0, ~DTR_CD_N_O,
                                   ~RTS_N};
            `MHF_OFF_MCO1: rd_d = mco1_q;
            `MHF_OFF_MCO2: rd_d = mco2_q;
            `MHF_OFF_CHG:  rd_d = {1'b0, chg_q, 4'h0};
            `MHF_OFF_IEN:  rd_d = ien_q;
            `MHF_OFF_OPT2: rd_d = {3'h0, opt2_q};
            `MHF_OFF_OPT3: rd_d = {4'h0, opt3_q};
            `MHF_OFF_CMD:  rd_d = {1'b0, cmd_q};
            `MHF_OFF_STAT: rd_d = {rx_en_q, tx_en_q, 2'h0, txfoff_q,
                                   txfon_q, rxfoff_q, rxfon_q};
            default:       rd_ok_d = 1'b0;
        endcase
    end

    // Read address and data
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
            RDATA   <= 32'h00000000;
            RRESP   <= `MHF_RESP_OK;
        end else if (CLK_EN) begin
            if (ARVALID && ARREADY) begin
                ARREADY <= 1'b0;
                RVALID  <= 1'b1;
                RDATA   <= {24'h000000, rd_d};
                RRESP   <= rd_ok_d ? `MHF_RESP_OK : `MHF_RESP_ERR;
            end else if (RVALID && RREADY) begin
                RVALID  <= 1'b0;
                ARREADY <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    // execute only when no command register write lands
    assign ex = (cmd_q != 7'h00 &&
                 !(do_wr && wlane_q && waddr_q == `MHF_OFF_CMD)) ?
                cmd_q : 7'h00;

    // Control registers and command word
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sig_q  <= 2'h0;
            mco1_q <= `MHF_RST_REG;
            mco2_q <= `MHF_RST_REG;
            ien_q  <= `MHF_RST_REG;
            opt2_q <= 5'h00;
            opt3_q <= 4'h0;
            cmd_q  <= 7'h00;
        end else if (CLK_EN) begin
            if (ex != 7'h00)
                cmd_q <= 7'h00;
            if (do_wr && wlane_q) begin
                case (waddr_q)
                    `MHF_OFF_SIG:  sig_q  <= wdata_q[1:0];
                    `MHF_OFF_MCO1: mco1_q <= wdata_q;
                    `MHF_OFF_MCO2: mco2_q <= wdata_q;
                    `MHF_OFF_IEN:  ien_q  <= wdata_q;
                    `MHF_OFF_OPT2: opt2_q <= wdata_q[4:0];
                    `MHF_OFF_OPT3: opt3_q <= wdata_q[3:0];
                    `MHF_OFF_CMD:  cmd_q  <= wdata_q[6:0];
                    default:       ;
                endcase
            end
        end
    end

    // Change bits: writing one clears, a new edge wins
    // sticky change bits
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            chg_q <= 3'h0;
        end else if (CLK_EN) begin
            if (do_wr && wlane_q && waddr_q == `MHF_OFF_CHG)
                chg_q <= (chg_q & ~wdata_q[`MHF_CHG_HI:`MHF_CHG_LO])
                         | evt;
            else
                chg_q <= chg_q | evt;
        end
    end

    // ------------------------------------------------------------
    // Channel enables and flow status
    // ------------------------------------------------------------
    assign rx_flow_chr = RX_CHAR_IS_XON | RX_CHAR_IS_XOFF;

    // Enables follow commands; reset wins
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tx_en_q <= 1'b0;
            rx_en_q <= 1'b0;
        end else if (CLK_EN) begin
            if (ex[`MHF_CMD_RST] || ex[`MHF_CMD_TXDIS])
                tx_en_q <= 1'b0;
            else if (ex[`MHF_CMD_TRANSMITTER_ENABLED_STATUS])
                tx_en_q <= 1'b1;
            if (ex[`MHF_CMD_RST] || ex[`MHF_CMD_RXDIS])
                rx_en_q <= 1'b0;
            else if (ex[`MHF_CMD_RECEIVER_ENABLED_STATUS])
                rx_en_q <= 1'b1;
        end
    end

    // Transmit flow status; commands beat the line
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            txfoff_q <= 1'b0;
            txfon_q  <= 1'b0;
        end else if (CLK_EN) begin
            if (ex[`MHF_CMD_RST] || ex[`MHF_CMD_TRANSMITTER_ENABLED_STATUS] ||
                ex[`MHF_CMD_TXDIS]) begin
                txfoff_q <= 1'b0;
                txfon_q  <= 1'b0;
            end else if (opt2_q[`MHF_OPT_TX_INBAND_FLOW_ENABLE] && RX_CHAR_STROBE &&
                         RX_CHAR_IS_XOFF) begin
                txfoff_q <= 1'b1;
                txfon_q  <= 1'b0;
            end else if (txfoff_q && RX_CHAR_STROBE &&
                         (RX_CHAR_IS_XON ||
                          opt2_q[`MHF_OPT_IXM])) begin
                txfoff_q <= 1'b0;
                txfon_q  <= 1'b1;
            end else if (TX_CHAR_START) begin
                txfon_q  <= 1'b0;
            end
        end
    end

    // Receive flow status; command set beats clear
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rxfoff_q <= 1'b0;
            rxfon_q  <= 1'b0;
        end else if (CLK_EN) begin
            if (ex[`MHF_CMD_XON]) begin
                rxfon_q  <= 1'b1;
                rxfoff_q <= 1'b0;
            end else if (ex[`MHF_CMD_XOFF]) begin
                rxfoff_q <= 1'b1;
            end else if (RX_CHAR_STROBE && !rx_flow_chr) begin
                rxfon_q  <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // DTR threshold flow control
    // ------------------------------------------------------------
    // low nibble, zero disables
    assign dtr_th = mco1_q[3:0];
    assign dtr_fc = (dtr_th != 4'h0) & dir_out;
    // code 0 acts as one character
    assign rx_th  = (opt3_q == 4'h0) ? 4'h1 : opt3_q;

    // Deactivation flag for automatic DTR
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dtr_off_q <= 1'b1;
        end else if (CLK_EN) begin
            if (dtr_fc && (ex[`MHF_CMD_RST] || ex[`MHF_CMD_RXDIS]))
                dtr_off_q <= 1'b1;
            else if (dtr_fc && ex[`MHF_CMD_RECEIVER_ENABLED_STATUS])
                dtr_off_q <= 1'b0;
            else if (dtr_fc && RX_CHAR_STROBE &&
                     RX_FIFO_LEVEL >= rx_th && RX_FIFO_LEVEL >= dtr_th)
                dtr_off_q <= 1'b1;
            else if (dtr_fc && RX_SERVICED && RX_FIFO_LEVEL < dtr_th)
                dtr_off_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Automatic RTS
    // ------------------------------------------------------------
    // hold RTS over the last character
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rts_hold_q <= 1'b0;
        end else if (CLK_EN) begin
            if ((ex[`MHF_CMD_RST] || ex[`MHF_CMD_TXDIS]) &&
                opt2_q[`MHF_OPT_RTS_AUTO_OUTPUT] && TX_SHIFT_BUSY)
                rts_hold_q <= 1'b1;
            else if (!TX_SHIFT_BUSY)
                rts_hold_q <= 1'b0;
        end
    end

    assign rts_act = sig_q[`MHF_SIG_RTS] |
                     (opt2_q[`MHF_OPT_RTS_AUTO_OUTPUT] &
                      ((tx_en_q & TX_DATA_WAITING) | rts_hold_q));
    assign dtr_act = sig_q[`MHF_SIG_DTR] |
                     (dtr_fc & rx_en_q & ~dtr_off_q);

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // Gating new loads only lets queued characters finish.
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RTS_N       <= 1'b1;
            DTR_CD_N_O  <= 1'b1;
            DTR_CD_N_OE <= 1'b0;
            TX_ALLOW    <= 1'b0;
            RX_ENABLE   <= 1'b0;
            SEND_XON    <= 1'b0;
            SEND_XOFF   <= 1'b0;
            MODEM_IRQ_N <= 1'b1;
        end else if (CLK_EN) begin
            RTS_N       <= ~rts_act;
            DTR_CD_N_O  <= ~dtr_act;
            DTR_CD_N_OE <= dir_out;
            TX_ALLOW    <= tx_en_q & ~txfoff_q &
                           (~opt2_q[`MHF_OPT_CTS_AUTO_ENABLE] | cts_a);
            RX_ENABLE   <= rx_en_q &
                           (~opt2_q[`MHF_OPT_DSR_AUTO_ENABLE] | dsr_a);
            SEND_XON    <= ex[`MHF_CMD_XON];
            SEND_XOFF   <= ex[`MHF_CMD_XOFF];
            MODEM_IRQ_N <= ~((chg_q != 3'h0) & ien_q[`MHF_IEN_MDM] &
                             SCAN_SELECT);
        end
    end

endmodule

// File: core/mhf_defines.vh
// Constants for the modem handshake and flow control block
`ifndef MHF_DEFINES_VH
`define MHF_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MHF_OFF_SIG   8'h00
`define MHF_OFF_MCO1  8'h04
`define MHF_OFF_MCO2  8'h08
`define MHF_OFF_CHG   8'h0C
`define MHF_OFF_IEN   8'h10
`define MHF_OFF_OPT2  8'h14
`define MHF_OFF_OPT3  8'h18
`define MHF_OFF_CMD   8'h1C
`define MHF_OFF_STAT  8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MHF_SIG_RTS   0
`define MHF_SIG_DTR   1
`define MHF_SIG_DIR   7
`define MHF_CHG_LO    4
`define MHF_CHG_HI    6
`define MHF_IEN_MDM   7
`define MHF_OPT_RTS_AUTO_OUTPUT 0
`define MHF_OPT_CTS_AUTO_ENABLE 1
`define MHF_OPT_DSR_AUTO_ENABLE 2
`define MHF_OPT_TX_INBAND_FLOW_ENABLE 3
`define MHF_OPT_IXM   4
`define MHF_CMD_RST   0
`define MHF_CMD_TRANSMITTER_ENABLED_STATUS  1
`define MHF_CMD_TXDIS 2
`define MHF_CMD_RECEIVER_ENABLED_STATUS  3
`define MHF_CMD_RXDIS 4
`define MHF_CMD_XON   5
`define MHF_CMD_XOFF  6

// ----------------------------------------------------------------
// Reset values, responses, timing
// ----------------------------------------------------------------
`define MHF_RST_REG   8'h00
`define MHF_RST_PINS  4'h7
`define MHF_RESP_OK   2'h0
`define MHF_RESP_ERR  2'h2
`define MHF_CLK_NS    25
`define MHF_SMP_MAX_NS 250000
`define MHF_SMP_CYC   (`MHF_SMP_MAX_NS / `MHF_CLK_NS - 1)

`endif

// File: core/mhf_sync.v
// Three-stage pin synchroniser with agreement filter
`include "mhf_defines.vh"

module mhf_sync #(
    parameter       W   = 4,
    parameter [W-1:0] RST = {W{1'b1}}
) (
    // Clock, reset, enable
    input  wire         clk,
    input  wire         arst_n,
    input  wire         ce,
    // Raw pin levels and filtered result
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);

    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;

    // ------------------------------------------------------------
    // Sampling chain
    // ------------------------------------------------------------
    // q moves only when stages two and three agree,
    // so a one-sample glitch is dropped.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= RST;
            s2_q <= RST;
            s3_q <= RST;
            q    <= RST;
        end else if (ce) begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q    <= (s2_q & s3_q) | (q & (s2_q ^ s3_q));
        end
    end

endmodule

// File: testbench/mhf_props.sv
// Port checker for the modem handshake core
`include "mhf_defines.vh"
module mhf_props #(
    parameter ADDR_W = 8
) (
    // Clock and reset
    input              SYS_CLK,
    input              ARST_N,
    // Register bus
    input              AWVALID,
    input              AWREADY,
    input              WVALID,
    input              WREADY,
    input              BVALID,
    input              ARVALID,
    input              ARREADY,
    input [ADDR_W-1:0] ARADDR,
    input              RVALID,
    input              RREADY,
    input [31:0]       RDATA,
    input [1:0]        RRESP,
    // Modem side
    input              RTS_N,
    input              DTR_CD_N_O,
    input              DTR_CD_N_OE,
    input              DTR_DIR_SEL,
    input              SCAN_SELECT,
    input              MODEM_IRQ_N
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    // Both write items taken at once
    sequence s_wr_take;
        AWVALID && AWREADY && WVALID && WREADY;
    endsequence
    sequence s_rd_take;
        ARVALID && ARREADY;
    endsequence
    a_rst_pins: assert property ($rose(ARST_N) |-> RTS_N
        && DTR_CD_N_O && !DTR_CD_N_OE && MODEM_IRQ_N)
        else $error("output active after reset");
    a_oe_dir: assert property ((!DTR_DIR_SEL)[*6] |-> !DTR_CD_N_OE)
        else $error("pin driven as input");
    a_irq_scan: assert property ($fell(MODEM_IRQ_N) |->
        $past(SCAN_SELECT)) else $error("irq without scanner");
    a_wr_resp: assert property (s_wr_take |-> ##[1:2] BVALID)
        else $error("no write response");
    a_rd_resp: assert property (s_rd_take |=> RVALID)
        else $error("no read response");
    a_r_hold: assert property (RVALID && !RREADY |=> RVALID
        && $stable(RDATA)) else $error("read data dropped");
    a_aw_lock: assert property (AWVALID && AWREADY |=> !AWREADY)
        else $error("awready stayed high");
    a_rd_unmap: assert property (s_rd_take ##0 (ARADDR > 8'h20)
        |=> RRESP == `MHF_RESP_ERR && RDATA == 32'h0)
        else $error("unmapped read");
endmodule
bind mhf_core mhf_props #(.ADDR_W(ADDR_W)) mhf_props_i (.SYS_CLK,
    .ARST_N, .AWVALID, .AWREADY, .WVALID, .WREADY, .BVALID,
    .ARVALID, .ARREADY, .ARADDR, .RVALID, .RREADY, .RDATA, .RRESP,
    .RTS_N, .DTR_CD_N_O, .DTR_CD_N_OE, .DTR_DIR_SEL, .SCAN_SELECT,
    .MODEM_IRQ_N);

// File: testbench/mhf_remote.sv
// Remote modem model on the handshake pins
module mhf_remote (
    // Requested line states, active high
    input  cts_on,
    input  dsr_on,
    input  cd_on,
    input  dir_hi,
    // Core drive of the shared pin
    input  dtr_o,
    input  dtr_oe,
    // Pins toward the core, active low except dir_sel
    output cts_n,
    output dsr_n,
    output cd_pin,
    output dir_sel
);
    timeunit 1ns;
    timeprecision 100ps;
    assign cts_n = !cts_on;
    assign dsr_n = !dsr_on;
    assign dir_sel = dir_hi;
    assign cd_pin = dtr_oe ? dtr_o : !cd_on;
endmodule

// File: testbench/tb.sv
// Bench for the modem handshake core
`include "mhf_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, arst_n, awv, wv, bready, arv, rready, scan;
    logic txw, busy, tst, rstb, rxon, rxoff, serv;
    logic cts_on, dsr_on, cd_on, dir_hi;
    logic [7:0] awa, ara, wd, rnd;
    logic [3:0] lvl;
    wire awr, wr, bv, arr, rv, tx_ok, sxon, sxoff, rx_en, irq_n;
    wire rts_n, cts_n, dsr_n, cd_pin, dtr_o, dtr_oe, dsel;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int err_total = 0, total_checks = 0;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    mhf_core #(.SAMPLE_CYCLES(4)) mhf_core_i (
        .SYS_CLK(clk), .ARST_N(arst_n), .CLK_EN(1'b1),
        .AWADDR(awa), .AWVALID(awv), .AWREADY(awr),
        .WDATA({24'h0, wd}), .WSTRB(4'hF), .WVALID(wv), .WREADY(wr),
        .BRESP(bresp), .BVALID(bv), .BREADY(bready), .ARADDR(ara),
        .ARVALID(arv), .ARREADY(arr), .RDATA(rdata), .RRESP(rresp),
        .RVALID(rv), .RREADY(rready), .RTS_N(rts_n), .CTS_N(cts_n),
        .DSR_N(dsr_n), .DTR_CD_N_I(cd_pin), .DTR_CD_N_O(dtr_o),
        .DTR_CD_N_OE(dtr_oe), .DTR_DIR_SEL(dsel),
        .TX_DATA_WAITING(txw), .TX_SHIFT_BUSY(busy),
        .TX_CHAR_START(tst), .TX_ALLOW(tx_ok), .SEND_XON(sxon),
        .SEND_XOFF(sxoff), .RX_CHAR_STROBE(rstb),
        .RX_CHAR_IS_XON(rxon), .RX_CHAR_IS_XOFF(rxoff),
        .RX_FIFO_LEVEL(lvl), .RX_SERVICED(serv), .RX_ENABLE(rx_en),
        .SCAN_SELECT(scan), .MODEM_IRQ_N(irq_n));
    mhf_remote mhf_remote_i (.cts_on(cts_on), .dsr_on(dsr_on),
        .cd_on(cd_on), .dir_hi(dir_hi), .dtr_o(dtr_o), .dtr_oe(dtr_oe),
        .cts_n(cts_n), .dsr_n(dsr_n), .cd_pin(cd_pin), .dir_sel(dsel));
    // System clock
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    function [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task bad(input string m);
        err_total++;
        $display("Error %0t: %s", $time, m);
    endtask
    task chk(input logic v, input logic e, input string m);
        total_checks++;
        if (v !== e) bad(m);
    endtask
    task w(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Bus write; bready once both items are taken
    task automatic wrt(input [7:0] a, input [7:0] d, input [1:0] r);
        bit got = 0;
        @(posedge clk);
        awa <= a; wd <= d; awv <= 1; wv <= 1;
        bq.push_back(r);
        do begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wr) wv <= 0;
            if (bv && bready) begin bready <= 0; got = 1; end
            else if (!awv && !wv) bready <= 1;
        end while (!got);
    endtask
    // Bus read; rready late so RDATA must stand
    task automatic rd(input [7:0] a, input [7:0] e, input [1:0] r);
        bit got = 0;
        @(posedge clk);
        ara <= a; arv <= 1;
        rq.push_back({r, 24'h0, e});
        do begin
            @(posedge clk);
            if (arr) arv <= 0;
            if (rv && rready) begin rready <= 0; got = 1; end
            else if (!arv) rready <= 1;
        end while (!got);
    endtask
    task rx(input logic on, input logic off);
        @(posedge clk);
        rstb <= 1; rxon <= on; rxoff <= off;
        @(posedge clk);
        rstb <= 0;
    endtask
    // Response monitor
    always @(posedge clk) begin
        if (bv && bready) begin
            total_checks++;
            if (bresp !== bq.pop_front()) bad("write response");
        end
        if (rv && rready) begin
            total_checks++;
            if ({rresp, rdata} !== rq.pop_front()) bad("read data");
        end
    end
    task tally_and_finish;
        if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog
    initial begin
        #300000;
        bad("timeout");
        tally_and_finish;
    end
    initial begin
        {awv, wv, bready, arv, rready, txw, busy, tst, rstb} = 0;
        {rxon, rxoff, serv, lvl, awa, ara, wd} = 0;
        {cts_on, dsr_on, cd_on, dir_hi, arst_n, scan} = 6'b110001;
        w(6);
        arst_n <= 1;
        w(12);
        rd(`MHF_OFF_SIG, 8'h50, 0);
        wrt(`MHF_OFF_SIG, 8'h01, 0);
        w(3); chk(rts_n, 0, "rts pin");
        wrt(`MHF_OFF_SIG, 8'h00, 0);
        wrt(`MHF_OFF_MCO1, 8'h10, 0);
        wrt(`MHF_OFF_IEN, 8'h80, 0);
        cts_on <= 0; w(12); cts_on <= 1; w(12);
        rd(`MHF_OFF_CHG, 8'h10, 0);
        chk(irq_n, 0, "irq");
        wrt(`MHF_OFF_CHG, 8'h10, 0);
        rd(`MHF_OFF_CHG, 8'h00, 0); w(3); chk(irq_n, 1, "irq off");
        rnd = lfsr(8'd81) & 8'h70;
        wrt(`MHF_OFF_MCO2, rnd, 0);
        rd(`MHF_OFF_MCO2, rnd, 0);
        wrt(`MHF_OFF_CMD, 8'h0A, 0); w(3);
        rd(`MHF_OFF_CMD, 8'h00, 0);
        rd(`MHF_OFF_STAT, 8'hC0, 0);
        wrt(`MHF_OFF_CMD, 8'h40, 0); w(1); chk(sxoff, 1, "sxoff");
        rd(`MHF_OFF_STAT, 8'hC2, 0);
        wrt(`MHF_OFF_CMD, 8'h20, 0); w(1); chk(sxon, 1, "sxon");
        rd(`MHF_OFF_STAT, 8'hC1, 0);
        wrt(`MHF_OFF_OPT2, 8'h08, 0);
        rx(0, 1); w(2); rd(`MHF_OFF_STAT, 8'hC9, 0);
        chk(tx_ok, 0, "txoff");
        rx(0, 0); w(2); rd(`MHF_OFF_STAT, 8'hC8, 0);
        rx(1, 0); w(2); rd(`MHF_OFF_STAT, 8'hC4, 0);
        chk(tx_ok, 1, "txon");
        @(posedge clk) tst <= 1; @(posedge clk) tst <= 0;
        w(2); rd(`MHF_OFF_STAT, 8'hC0, 0);
        rx(0, 1); wrt(`MHF_OFF_CMD, 8'h02, 0); w(3);
        rd(`MHF_OFF_STAT, 8'hC0, 0); chk(tx_ok, 1, "tx en");
        wrt(`MHF_OFF_OPT2, 8'h18, 0);
        rx(0, 1); rx(0, 0); w(2); rd(`MHF_OFF_STAT, 8'hC4, 0);
        wrt(`MHF_OFF_OPT2, 8'h02, 0);
        cts_on <= 0; w(12); chk(tx_ok, 0, "cts gate");
        cts_on <= 1; w(12); chk(tx_ok, 1, "cts open");
        wrt(`MHF_OFF_OPT2, 8'h04, 0);
        dsr_on <= 0; w(12); chk(rx_en, 0, "dsr gate");
        dsr_on <= 1; w(12); chk(rx_en, 1, "dsr open");
        wrt(`MHF_OFF_OPT2, 8'h01, 0);
        txw <= 1; w(3); chk(rts_n, 0, "auto rts");
        busy <= 1; wrt(`MHF_OFF_CMD, 8'h04, 0);
        w(3); chk(rts_n, 0, "rts held");
        busy <= 0; w(3); chk(rts_n, 1, "rts drop");
        dir_hi <= 1; wrt(`MHF_OFF_MCO1, 8'h02, 0);
        wrt(`MHF_OFF_OPT3, 8'h01, 0); wrt(`MHF_OFF_CMD, 8'h08, 0);
        w(12); chk(dtr_o, 0, "dtr on");
        chk(dtr_oe, 1, "dtr oe");
        lvl <= 2; rx(0, 0); w(3); chk(dtr_o, 1, "dtr full");
        lvl <= 0; @(posedge clk) serv <= 1; @(posedge clk) serv <= 0;
        w(3); chk(dtr_o, 0, "dtr back");
        wrt(`MHF_OFF_CMD, 8'h10, 0); w(3); chk(dtr_o, 1, "rx dis");
        rd(8'h40, 8'h00, `MHF_RESP_ERR);
        wrt(`MHF_OFF_STAT, 8'h00, `MHF_RESP_ERR);
        wrt(`MHF_OFF_SIG, 8'h03, 0); arst_n <= 0; w(2);
        chk(rts_n, 1, "rst rts"); chk(dtr_o, 1, "rst dtr");
        tally_and_finish;
    end
endmodule
